// >>> hw_monitor_readout_regs.sv
/*
 * Hardware-monitor register file with a host index/data port and a
 * serial two-wire slave port into the same registers.
 * Assumes bus pins are already synchronous to core_clk and that an
 * outside converter delivers one result at a time on conv_in.
 */
`timescale 1ns/100ps
`default_nettype none
module hw_monitor_readout_regs #(
    parameter logic [15:0] INDEX_PORT = hwmon_pkg::HOST_INDEX_PORT,
    parameter logic [15:0] DATA_PORT = hwmon_pkg::HOST_DATA_PORT,
    parameter logic [6:0] SLAVE_ADDR_DEFAULT = hwmon_pkg::SLAVE_ADDR_RESET
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // host index/data port
    input wire logic [15:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // serial slave pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // converter results
    input wire hwmon_pkg::conv_result_t conv_in,
    // sensor selection
    output hwmon_pkg::sense_mode_t system_temp_input_mode,
    output hwmon_pkg::sense_mode_t processor_temp_input_mode
);
    // ==========================================
    // storage
    logic [7:0] volt_q [hwmon_pkg::NUM_VOLT];
    logic [7:0] sys_temp_q;
    logic [8:0] cpu_temp_q;
    logic [6:0] slave_addr_q;
    logic [7:0] bank_q;
    logic [7:0] method_q;
    logic [7:0] type_q;
    logic [7:0] aux_q;
    logic [7:0] index_q;
    logic [7:0] host_rdata_q;

    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic host_data_wr;
    logic sl_wr;
    logic [7:0] sl_ptr_q;
    logic [7:0] sl_shift_q;
    logic [7:0] sl_rd_byte;

    // banked read decode, shared by both ports
    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        logic [2:0] bank;
        bank = bank_q[2:0];
        read_reg = hwmon_pkg::BYTE_ZERO;
        if (idx == hwmon_pkg::IDX_BANK_SEL) begin
            read_reg = bank_q;
        end else if (bank == hwmon_pkg::BANK_MAIN) begin
            if (idx >= hwmon_pkg::IDX_VOLT_FIRST && idx <= hwmon_pkg::IDX_VOLT_LAST) begin
                read_reg = volt_q[3'(idx - hwmon_pkg::IDX_VOLT_FIRST)];
            end else if (idx == hwmon_pkg::IDX_SYS_TEMP) begin
                read_reg = sys_temp_q;
            end else if (idx == hwmon_pkg::IDX_SLAVE_ADDR) begin
                read_reg = {1'b0, slave_addr_q};
            end else if (idx == hwmon_pkg::IDX_SENSE_METHOD) begin
                read_reg = method_q;
            end else if (idx == hwmon_pkg::IDX_SENSE_TYPE) begin
                read_reg = type_q;
            end else if (idx == hwmon_pkg::IDX_SENSE_AUX) begin
                read_reg = aux_q;
            end
        end else if (bank == hwmon_pkg::BANK_CPU) begin
            if (idx == hwmon_pkg::IDX_CPU_TEMP_HI) begin
                read_reg = cpu_temp_q[8:1];
            end else if (idx == hwmon_pkg::IDX_CPU_TEMP_LO) begin
                read_reg = {cpu_temp_q[0], 7'h00};
            end
        end else if (bank == hwmon_pkg::BANK_EXTRA) begin
            if (idx == hwmon_pkg::IDX_BATTERY) begin
                read_reg = volt_q[hwmon_pkg::CH_BATTERY[2:0]];
            end else if (idx == hwmon_pkg::IDX_STANDBY) begin
                read_reg = volt_q[hwmon_pkg::CH_STANDBY[2:0]];
            end
        end
    endfunction

    // ==========================================
    // write arbitration: host wins a same-cycle clash
    assign host_data_wr = host_wr && (host_addr == DATA_PORT);
    always_comb begin
        wr_en = host_data_wr || sl_wr;
        wr_idx = host_data_wr ? index_q : sl_ptr_q;
        wr_data = host_data_wr ? host_wdata : sl_shift_q;
    end

    // ==========================================
    // host port
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            index_q <= hwmon_pkg::BYTE_ZERO;
        end else if (host_wr && host_addr == INDEX_PORT) begin
            index_q <= host_wdata;
        end
    end

    // reads are side-effect free, only the answer flop moves
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_rdata_q <= hwmon_pkg::BYTE_ZERO;
        end else if (host_rd && host_addr == INDEX_PORT) begin
            host_rdata_q <= index_q;
        end else if (host_rd && host_addr == DATA_PORT) begin
            host_rdata_q <= read_reg(index_q);
        end
    end
    assign host_rdata = host_rdata_q;

    // ==========================================
    // writable configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bank_q <= hwmon_pkg::BYTE_ZERO;
            slave_addr_q <= SLAVE_ADDR_DEFAULT;
            method_q <= hwmon_pkg::BYTE_ZERO;
            type_q <= hwmon_pkg::BYTE_ZERO;
            aux_q <= hwmon_pkg::BYTE_ZERO;
        end else if (wr_en) begin
            if (wr_idx == hwmon_pkg::IDX_BANK_SEL) begin
                bank_q <= wr_data;
            end else if (bank_q[2:0] == hwmon_pkg::BANK_MAIN) begin
                if (wr_idx == hwmon_pkg::IDX_SLAVE_ADDR) begin
                    slave_addr_q <= wr_data[6:0];
                end
                if (wr_idx == hwmon_pkg::IDX_SENSE_METHOD) begin
                    method_q <= wr_data;
                end
                if (wr_idx == hwmon_pkg::IDX_SENSE_TYPE) begin
                    type_q <= wr_data;
                end
                if (wr_idx == hwmon_pkg::IDX_SENSE_AUX) begin
                    aux_q <= wr_data;
                end
            end
        end
    end

    // ==========================================
    // sensor mode decode
    function automatic hwmon_pkg::sense_mode_t mode_of(input logic diode, input logic cur);
        if (!diode) begin
            mode_of = hwmon_pkg::SENSE_THERMISTOR;
        end else if (cur) begin
            mode_of = hwmon_pkg::SENSE_DIODE_CURRENT;
        end else begin
            mode_of = hwmon_pkg::SENSE_DIODE_VOLTAGE;
        end
    endfunction

    always_comb begin
        system_temp_input_mode = mode_of(type_q[hwmon_pkg::SYS_DIODE_BIT],
            method_q[hwmon_pkg::SYS_CURRENT_BIT]);
        processor_temp_input_mode = mode_of(type_q[hwmon_pkg::CPU_DIODE_BIT],
            method_q[hwmon_pkg::CPU_CURRENT_BIT]);
    end

    // ==========================================
    // conversion results
    // codes are stored raw; divider scaling is left to software
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < hwmon_pkg::NUM_VOLT; i++) begin
                volt_q[i] <= hwmon_pkg::BYTE_ZERO;
            end
        end else if (conv_in.valid && conv_in.channel < hwmon_pkg::CH_SYS_TEMP) begin
            volt_q[conv_in.channel[2:0]] <= conv_in.code[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sys_temp_q <= hwmon_pkg::BYTE_ZERO;
            cpu_temp_q <= 9'h000;
        end else if (conv_in.valid) begin
            if (conv_in.channel == hwmon_pkg::CH_SYS_TEMP) begin
                sys_temp_q <= conv_in.code[7:0];
            end
            if (conv_in.channel == hwmon_pkg::CH_CPU_TEMP) begin
                cpu_temp_q <= conv_in.code;
            end
        end
    end

    // ==========================================
    // serial slave
    hwmon_pkg::slave_state_t sl_state_q;
    logic scl_q;
    logic sda_q;
    logic [3:0] sl_cnt_q;
    logic sl_read_q;
    logic sl_nack_q;
    logic sda_oe_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic byte_done;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign bus_start = scl_in && scl_q && sda_q && !sda_in;
    assign bus_stop = scl_in && scl_q && !sda_q && sda_in;
    assign byte_done = sl_cnt_q == 4'(hwmon_pkg::BIT_COUNT_BYTE);
    assign sl_wr = scl_fall && byte_done && sl_state_q == hwmon_pkg::SL_WDATA;
    assign sl_rd_byte = read_reg(sl_ptr_q);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sl_state_q <= hwmon_pkg::SL_IDLE;
            sl_cnt_q <= 4'h0;
            sl_shift_q <= hwmon_pkg::BYTE_ZERO;
            sl_ptr_q <= hwmon_pkg::BYTE_ZERO;
            sl_read_q <= 1'b0;
            sl_nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (bus_start) begin
            sl_state_q <= hwmon_pkg::SL_ADDR;
            sl_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (bus_stop) begin
            sl_state_q <= hwmon_pkg::SL_IDLE;
            sda_oe_q <= 1'b0;
        end else if (scl_rise) begin
            unique case (sl_state_q)
                hwmon_pkg::SL_ADDR, hwmon_pkg::SL_PTR, hwmon_pkg::SL_WDATA: begin
                    sl_shift_q <= {sl_shift_q[6:0], sda_in};
                    sl_cnt_q <= sl_cnt_q + 4'h1;
                end
                hwmon_pkg::SL_RDATA_ACK: begin
                    sl_nack_q <= sda_in;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (sl_state_q)
                hwmon_pkg::SL_ADDR: begin
                    if (byte_done && sl_shift_q[7:1] == slave_addr_q) begin
                        sl_read_q <= sl_shift_q[0];
                        sda_oe_q <= 1'b1;
                        sl_state_q <= hwmon_pkg::SL_ADDR_ACK;
                    end else if (byte_done) begin
                        sl_state_q <= hwmon_pkg::SL_IDLE;
                    end
                end
                hwmon_pkg::SL_ADDR_ACK: begin
                    sl_cnt_q <= 4'h0;
                    if (sl_read_q) begin
                        sl_shift_q <= sl_rd_byte;
                        sda_oe_q <= !sl_rd_byte[7];
                        sl_cnt_q <= 4'h1;
                        sl_state_q <= hwmon_pkg::SL_RDATA;
                    end else begin
                        sda_oe_q <= 1'b0;
                        sl_state_q <= hwmon_pkg::SL_PTR;
                    end
                end
                hwmon_pkg::SL_PTR: begin
                    if (byte_done) begin
                        sl_ptr_q <= sl_shift_q;
                        sda_oe_q <= 1'b1;
                        sl_state_q <= hwmon_pkg::SL_PTR_ACK;
                    end
                end
                hwmon_pkg::SL_WDATA: begin
                    if (byte_done) begin
                        sda_oe_q <= 1'b1;
                        sl_state_q <= hwmon_pkg::SL_WDATA_ACK;
                    end
                end
                hwmon_pkg::SL_PTR_ACK, hwmon_pkg::SL_WDATA_ACK: begin
                    sda_oe_q <= 1'b0;
                    sl_cnt_q <= 4'h0;
                    sl_state_q <= hwmon_pkg::SL_WDATA;
                end
                hwmon_pkg::SL_RDATA: begin
                    if (byte_done) begin
                        sda_oe_q <= 1'b0;
                        sl_state_q <= hwmon_pkg::SL_RDATA_ACK;
                    end else begin
                        sda_oe_q <= !sl_shift_q[3'(7 - sl_cnt_q)];
                        sl_cnt_q <= sl_cnt_q + 4'h1;
                    end
                end
                hwmon_pkg::SL_RDATA_ACK: begin
                    if (sl_nack_q) begin
                        sl_state_q <= hwmon_pkg::SL_IDLE;
                    end else begin
                        // same register again: pointer does not advance
                        sl_shift_q <= sl_rd_byte;
                        sda_oe_q <= !sl_rd_byte[7];
                        sl_cnt_q <= 4'h1;
                        sl_state_q <= hwmon_pkg::SL_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// >>> hwmon_pkg.sv
/*
 * Constants and types for the hardware-monitor register readout block.
 * Assumes a single core clock; results arrive from an external converter.
 */
package hwmon_pkg;
    // ==========================================
    // register indices
    localparam logic [7:0] IDX_VOLT_FIRST = 8'h20;
    localparam logic [7:0] IDX_VOLT_LAST = 8'h25;
    localparam logic [7:0] IDX_ANALOG_SUPPLY = 8'h22;
    localparam logic [7:0] IDX_MAIN_SUPPLY = 8'h23;
    localparam logic [7:0] IDX_SYS_TEMP = 8'h27;
    localparam logic [7:0] IDX_SLAVE_ADDR = 8'h48;
    localparam logic [7:0] IDX_BANK_SEL = 8'h4E;
    localparam logic [7:0] IDX_CPU_TEMP_HI = 8'h50;
    localparam logic [7:0] IDX_CPU_TEMP_LO = 8'h51;
    localparam logic [7:0] IDX_SENSE_METHOD = 8'h59;
    localparam logic [7:0] IDX_SENSE_TYPE = 8'h5D;
    localparam logic [7:0] IDX_SENSE_AUX = 8'h5E;
    // extra channels, bank 5
    localparam logic [7:0] IDX_BATTERY = 8'h50;
    localparam logic [7:0] IDX_STANDBY = 8'h51;
    localparam logic [2:0] BANK_MAIN = 3'h0;
    localparam logic [2:0] BANK_CPU = 3'h1;
    localparam logic [2:0] BANK_EXTRA = 3'h5;
    // ==========================================
    // host port and resets
    localparam logic [15:0] HOST_INDEX_PORT = 16'h0295;
    localparam logic [15:0] HOST_DATA_PORT = 16'h0296;
    localparam logic [6:0] SLAVE_ADDR_RESET = 7'h2D;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // ==========================================
    // sensor selection fields
    localparam int SYS_DIODE_BIT = 1;
    localparam int CPU_DIODE_BIT = 2;
    localparam int SYS_CURRENT_BIT = 4;
    localparam int CPU_CURRENT_BIT = 5;
    // ==========================================
    // converter channels: 0..7 voltages, then temperatures
    localparam logic [3:0] CH_CORE = 4'h0;
    localparam logic [3:0] CH_GEN0 = 4'h1;
    localparam logic [3:0] CH_ANALOG = 4'h2;
    localparam logic [3:0] CH_MAIN = 4'h3;
    localparam logic [3:0] CH_GEN1 = 4'h4;
    localparam logic [3:0] CH_GEN2 = 4'h5;
    localparam logic [3:0] CH_BATTERY = 4'h6;
    localparam logic [3:0] CH_STANDBY = 4'h7;
    localparam logic [3:0] CH_SYS_TEMP = 4'h8;
    localparam logic [3:0] CH_CPU_TEMP = 4'h9;
    localparam int NUM_VOLT = 8;
    localparam int BIT_COUNT_BYTE = 8;

    typedef struct packed {
        logic valid;
        logic [3:0] channel;
        logic [8:0] code;
    } conv_result_t;

    typedef enum logic [1:0] {
        SENSE_THERMISTOR = 2'h0,
        SENSE_DIODE_VOLTAGE = 2'h1,
        SENSE_DIODE_CURRENT = 2'h2
    } sense_mode_t;

    typedef enum logic [8:0] {
        SL_IDLE = 9'h001,
        SL_ADDR = 9'h002,
        SL_ADDR_ACK = 9'h004,
        SL_PTR = 9'h008,
        SL_PTR_ACK = 9'h010,
        SL_WDATA = 9'h020,
        SL_WDATA_ACK = 9'h040,
        SL_RDATA = 9'h080,
        SL_RDATA_ACK = 9'h100
    } slave_state_t;
endpackage

// >>> hw_monitor_readout_regs_monitor.sv
/*
 * Port-level checker for the hardware-monitor register block.
 * Assumes host strobes, converter results and serial pins are sampled on core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module hw_monitor_readout_regs_monitor #(
    parameter logic [15:0] INDEX_PORT = 16'h0295,
    parameter logic [15:0] DATA_PORT = 16'h0296
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // host port
    input wire logic [15:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // converter and sensor selection
    input wire hwmon_pkg::conv_result_t conv_in,
    input wire hwmon_pkg::sense_mode_t system_temp_input_mode,
    input wire hwmon_pkg::sense_mode_t processor_temp_input_mode
);
    // ==========================================
    // shadow of host-side state
    logic [7:0] idx_q;
    logic [2:0] bank_q;
    logic [7:0] main_q;
    logic [7:0] sys_q;
    wire any_rd = host_rd && (host_addr == INDEX_PORT || host_addr == DATA_PORT);
    wire data_rd = host_rd && host_addr == DATA_PORT;
    // only host writes are tracked; serial writes to 4Eh would desync this
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idx_q <= hwmon_pkg::BYTE_ZERO;
            bank_q <= hwmon_pkg::BANK_MAIN;
        end else if (host_wr && host_addr == INDEX_PORT) begin
            idx_q <= host_wdata;
        end else if (host_wr && host_addr == DATA_PORT && idx_q == hwmon_pkg::IDX_BANK_SEL) begin
            bank_q <= host_wdata[2:0];
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            main_q <= hwmon_pkg::BYTE_ZERO;
            sys_q <= hwmon_pkg::BYTE_ZERO;
        end else if (conv_in.valid) begin
            if (conv_in.channel == hwmon_pkg::CH_MAIN) main_q <= conv_in.code[7:0];
            if (conv_in.channel == hwmon_pkg::CH_SYS_TEMP) sys_q <= conv_in.code[7:0];
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_rdata_hold;
        !any_rd |=> $stable(host_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
    property p_unmapped_zero;
        data_rd && idx_q < 8'h20 |=> host_rdata == hwmon_pkg::BYTE_ZERO;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped index not zero");
    property p_bank_readback;
        data_rd && idx_q == hwmon_pkg::IDX_BANK_SEL |=> host_rdata[2:0] == bank_q;
    endproperty
    a_bank_readback: assert property (p_bank_readback) else $error("bank select readback");
    property p_addr_top_bit;
        data_rd && idx_q == hwmon_pkg::IDX_SLAVE_ADDR |=> !host_rdata[7];
    endproperty
    a_addr_top_bit: assert property (p_addr_top_bit) else $error("slave address bit 7 set");
    property p_main_supply;
        data_rd && idx_q == hwmon_pkg::IDX_MAIN_SUPPLY && bank_q == hwmon_pkg::BANK_MAIN
            |=> host_rdata == main_q;
    endproperty
    a_main_supply: assert property (p_main_supply) else $error("main supply result");
    property p_sys_temp;
        data_rd && idx_q == hwmon_pkg::IDX_SYS_TEMP && bank_q == hwmon_pkg::BANK_MAIN
            |=> host_rdata == sys_q;
    endproperty
    a_sys_temp: assert property (p_sys_temp) else $error("system temperature result");
    property p_oe_edge;
        $changed(sda_oe) |-> !$past(scl_in, 1) && $past(scl_in, 2);
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("data line moved off clock fall");
    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data output not low");
    property p_mode_legal;
        !(system_temp_input_mode == 2'h3 || processor_temp_input_mode == 2'h3);
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal sensor mode");
    c_read: cover property (data_rd);
    c_ack: cover property ($rose(sda_oe));
    c_cpu_conv: cover property (conv_in.valid && conv_in.channel == hwmon_pkg::CH_CPU_TEMP);
endmodule
bind hw_monitor_readout_regs hw_monitor_readout_regs_monitor #(
    .INDEX_PORT(INDEX_PORT),
    .DATA_PORT(DATA_PORT)
) i_hw_monitor_readout_regs_monitor (
    .core_clk(core_clk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .conv_in(conv_in), .system_temp_input_mode(system_temp_input_mode),
    .processor_temp_input_mode(processor_temp_input_mode)
);
`default_nettype wire

// >>> i2c_master_model.sv
/*
 * Behavioural two-wire bus master facing the monitor's serial slave.
 * Assumes a pull-up on the data line and core_clk as its time base.
 */
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model #(
    parameter int HALF = 4
) (
    // time base
    input wire logic core_clk,
    // wire levels seen by the device
    output var logic scl_in,
    output wire logic sda_in,
    // device pulls the data line low
    input wire logic sda_oe
);
    // ==========================================
    // wired-and data line
    logic sda_m;
    // pull-up: released by both parties reads high
    assign sda_in = sda_m & ~sda_oe;
    initial begin
        scl_in = 1'b1;
        sda_m = 1'b1;
    end
    task automatic gap();
        repeat (HALF) @(posedge core_clk);
    endtask
    // ==========================================
    // bus conditions; clock idles high between frames
    task automatic start();
        gap();
        sda_m <= 1'b1;
        gap();
        scl_in <= 1'b1;
        gap();
        sda_m <= 1'b0;
        gap();
        scl_in <= 1'b0;
    endtask
    task automatic stop();
        gap();
        sda_m <= 1'b0;
        gap();
        scl_in <= 1'b1;
        gap();
        sda_m <= 1'b1;
        gap();
    endtask
    task automatic clk_bit(input logic b, output logic r);
        gap();
        sda_m <= b;
        gap();
        scl_in <= 1'b1;
        gap();
        r = sda_in;
        scl_in <= 1'b0;
    endtask
    // one byte msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] wb, input logic ack_in, output logic [7:0] rb,
                        output logic ack_seen);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(wb[i], r);
            rb[i] = r;
        end
        clk_bit(ack_in, r);
        ack_seen = ~r;
    endtask
endmodule
`default_nettype wire

// >>> hw_monitor_readout_regs_tb_top.sv
/*
 * Self-checking bench: host index/data accesses, converter results, serial frames.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/100ps
`default_nettype none
module hw_monitor_readout_regs_tb_top;
    localparam int TIMEOUT = 20000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] host_addr = 16'h0000;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] host_rdata;
    logic sda_out;
    logic sda_oe;
    wire scl_in;
    wire sda_in;
    hwmon_pkg::conv_result_t conv_in = '0;
    hwmon_pkg::sense_mode_t sys_mode;
    hwmon_pkg::sense_mode_t cpu_mode;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic ack;
    always #4 core_clk = ~core_clk;
    hw_monitor_readout_regs i_hw_monitor_readout_regs (
        .core_clk(core_clk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .conv_in(conv_in), .system_temp_input_mode(sys_mode),
        .processor_temp_input_mode(cpu_mode));
    i2c_master_model i_i2c_master_model (.core_clk(core_clk), .scl_in(scl_in),
        .sda_in(sda_in), .sda_oe(sda_oe));
    // ==========================================
    // access tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic host_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= wr;
        host_rd <= ~wr;
        @(posedge core_clk);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
    endtask
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        host_op(1'b1, hwmon_pkg::HOST_INDEX_PORT, idx);
        host_op(1'b1, hwmon_pkg::HOST_DATA_PORT, d);
    endtask
    task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
        host_op(1'b1, hwmon_pkg::HOST_INDEX_PORT, idx);
        host_op(1'b0, hwmon_pkg::HOST_DATA_PORT, 8'h00);
        @(negedge core_clk);
        check(host_rdata, exp);
    endtask
    task automatic conv(input logic [3:0] ch, input logic [8:0] code);
        @(posedge core_clk);
        conv_in <= {1'b1, ch, code};
        @(posedge core_clk);
        conv_in.valid <= 1'b0;
    endtask
    task automatic sbyte(input logic [7:0] b, input logic exp_ack);
        i_i2c_master_model.xfer(b, 1'b1, rd, ack);
        check({7'h00, ack}, {7'h00, exp_ack});
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            mismatches++;
            end_sim();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        reg_chk(hwmon_pkg::IDX_SLAVE_ADDR, {1'b0, hwmon_pkg::SLAVE_ADDR_RESET});
        reg_chk(hwmon_pkg::IDX_BANK_SEL, 8'h00);
        check({6'h00, sys_mode}, {6'h00, hwmon_pkg::SENSE_THERMISTOR});
        for (int ch = 0; ch < 9; ch++) conv(4'(ch), 9'h0A0 + 9'(ch));
        conv(hwmon_pkg::CH_CPU_TEMP, 9'h0FB);
        // channel 12 has no register and must leave all others alone
        conv(4'hC, 9'h055);
        for (int ch = 0; ch < 6; ch++) reg_chk(8'h20 + 8'(ch), 8'hA0 + 8'(ch));
        reg_chk(hwmon_pkg::IDX_SYS_TEMP, 8'hA8);
        conv(hwmon_pkg::CH_SYS_TEMP, 9'h0C9);
        reg_wr(hwmon_pkg::IDX_SYS_TEMP, 8'h00);
        reg_chk(hwmon_pkg::IDX_SYS_TEMP, 8'hC9);
        reg_chk(8'h00, 8'h00);
        reg_wr(hwmon_pkg::IDX_BANK_SEL, 8'h01);
        reg_chk(hwmon_pkg::IDX_CPU_TEMP_HI, 8'h7D);
        reg_chk(hwmon_pkg::IDX_CPU_TEMP_LO, 8'h80);
        reg_wr(hwmon_pkg::IDX_BANK_SEL, 8'h05);
        reg_chk(hwmon_pkg::IDX_BATTERY, 8'hA6);
        reg_chk(hwmon_pkg::IDX_STANDBY, 8'hA7);
        reg_wr(hwmon_pkg::IDX_BANK_SEL, 8'h00);
        reg_wr(hwmon_pkg::IDX_SENSE_TYPE, 8'h02);
        @(negedge core_clk);
        check({6'h00, sys_mode}, {6'h00, hwmon_pkg::SENSE_DIODE_VOLTAGE});
        reg_wr(hwmon_pkg::IDX_SENSE_METHOD, 8'h10);
        @(negedge core_clk);
        check({6'h00, sys_mode}, {6'h00, hwmon_pkg::SENSE_DIODE_CURRENT});
        reg_wr(hwmon_pkg::IDX_SENSE_TYPE, 8'h04);
        reg_wr(hwmon_pkg::IDX_SENSE_METHOD, 8'h20);
        @(negedge core_clk);
        check({6'h00, cpu_mode}, {6'h00, hwmon_pkg::SENSE_DIODE_CURRENT});
        check({6'h00, sys_mode}, {6'h00, hwmon_pkg::SENSE_THERMISTOR});
        reg_wr(hwmon_pkg::IDX_SENSE_METHOD, 8'h00);
        @(negedge core_clk);
        check({6'h00, cpu_mode}, {6'h00, hwmon_pkg::SENSE_DIODE_VOLTAGE});
        // serial write then host readback of the same register
        reg_wr(hwmon_pkg::IDX_SLAVE_ADDR, 8'h35);
        i_i2c_master_model.start();
        sbyte({7'h35, 1'b0}, 1'b1);
        sbyte(hwmon_pkg::IDX_SENSE_AUX, 1'b1);
        sbyte(8'h5A, 1'b1);
        i_i2c_master_model.stop();
        reg_chk(hwmon_pkg::IDX_SENSE_AUX, 8'h5A);
        i_i2c_master_model.start();
        sbyte({7'h35, 1'b1}, 1'b1);
        i_i2c_master_model.xfer(8'hFF, 1'b1, rd, ack);
        i_i2c_master_model.stop();
        check(rd, 8'h5A);
        // pointer-only frame, then a bare read must use the kept pointer
        i_i2c_master_model.start();
        sbyte({7'h35, 1'b0}, 1'b1);
        sbyte(hwmon_pkg::IDX_SYS_TEMP, 1'b1);
        i_i2c_master_model.stop();
        i_i2c_master_model.start();
        sbyte({7'h35, 1'b1}, 1'b1);
        i_i2c_master_model.xfer(8'hFF, 1'b1, rd, ack);
        i_i2c_master_model.stop();
        check(rd, 8'hC9);
        i_i2c_master_model.start();
        sbyte({hwmon_pkg::SLAVE_ADDR_RESET, 1'b0}, 1'b0);
        i_i2c_master_model.stop();
        // second reset in mid-run
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        reg_chk(hwmon_pkg::IDX_SLAVE_ADDR, {1'b0, hwmon_pkg::SLAVE_ADDR_RESET});
        reg_chk(hwmon_pkg::IDX_SYS_TEMP, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
